//--- idct_pkg.sv
// Purpose: Shared constants, types and the cosine table of the 8x8 inverse transform.
// Assumes: One clock domain; all users import the whole package.
// Notes:   Table entries are 0.5*cos(a*pi/16) scaled by 2**TAB_FRAC and rounded.
`default_nettype none

package idct_pkg;

    // ==========================================================
    // Data widths and scaling
    localparam int COEF_W = 12;
    localparam int PIX_W = 8;
    localparam int PIX_W_MAX = 12;
    localparam int TAB_FRAC = 12;
    localparam int TAB_W = 14;
    localparam int MID_FRAC = 3;
    localparam int MID_W = 18;
    localparam int OUT_SCALE_LOG = 7;

    // ==========================================================
    // Timing
    localparam int BLK_LEN = 64;
    localparam int READY_LAT = 182;
    localparam int OUT_PIPE = 4;
    localparam logic [7:0] COL_OFS = 8'(BLK_LEN);
    localparam logic [7:0] ROW_OFS = 8'(READY_LAT - 1 - OUT_PIPE);

    // ==========================================================
    // Sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'h0,
        SEQ_ARMED = 2'h1,
        SEQ_RUN = 2'h2
    } seq_state_t;

    // ==========================================================
    // Weight for output index m and input index k
    function automatic logic signed [TAB_W-1:0] cos_tab(
        input logic [2:0] m,
        input logic [2:0] k
    );
        logic [6:0] prod;
        logic [5:0] a;
        logic neg;
        logic signed [TAB_W-1:0] v;
        prod = 7'({3'h0, m, 1'b1}) * 7'({4'h0, k});
        a = {1'b0, prod[4:0]};
        neg = 1'b0;
        v = 14'h0000;
        if (a > 6'h10) begin
            a = 6'h20 - a;
        end
        if (a > 6'h08) begin
            neg = 1'b1;
            a = 6'h10 - a;
        end
        case (a)
            6'h00: v = 14'h0800;
            6'h01: v = 14'h07D9;
            6'h02: v = 14'h0764;
            6'h03: v = 14'h06A7;
            6'h04: v = 14'h05A8;
            6'h05: v = 14'h0472;
            6'h06: v = 14'h0310;
            6'h07: v = 14'h0190;
            default: v = 14'h0000;
        endcase
        cos_tab = neg ? -v : v;
    endfunction : cos_tab

endpackage : idct_pkg

`default_nettype wire

//--- point8_stage.sv
// Purpose: One 8-point inverse transform output per clock, selected by sel.
// Assumes: Inputs stay valid for the enabled cycle; result is registered.
// Notes:   Rounds half up before the arithmetic shift; result is truncated to OUT_W.
`default_nettype none

module point8_stage #(
    parameter int IN_W = 12,
    parameter int OUT_W = 18,
    parameter int SHIFT = 9
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic en,
    input wire logic [8*IN_W-1:0] x_flat,
    input wire logic [2:0] sel,
    output logic signed [OUT_W-1:0] y
);
    import idct_pkg::*;

    localparam int ACC_W = IN_W + TAB_W + 3;
    localparam logic signed [ACC_W-1:0] RND = ACC_W'(1) <<< (SHIFT - 1);

    logic signed [ACC_W-1:0] term [0:7];
    logic signed [ACC_W-1:0] acc;

    // ==========================================================
    // Eight weighted terms
    for (genvar g = 0; g < 8; g++) begin : g_mul
        assign term[g] = ACC_W'($signed(x_flat[g*IN_W +: IN_W]) * cos_tab(sel, 3'(g)));
    end

    always_comb begin
        acc = RND;
        for (int i = 0; i < 8; i++) begin
            acc = acc + term[i];
        end
    end

    // ==========================================================
    // Registered, scaled result
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            y <= '0;
        end else if (en) begin
            y <= OUT_W'(acc >>> SHIFT);
        end
    end

endmodule : point8_stage

`default_nettype wire

//--- pair_buffer.sv
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: en low freezes contents and occupancy.
// Notes:   Push and pop in the same cycle are allowed at one entry.
`default_nettype none

module pair_buffer #(
    parameter int W = 9
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] slot0;
    logic [W-1:0] slot1;
    logic [1:0] fill;
    logic push;
    logic pop;

    assign in_ready = (fill != 2'h2);
    assign out_valid = (fill != 2'h0);
    assign out_data = slot0;
    assign push = en & in_valid & in_ready;
    assign pop = en & out_valid & out_ready;

    // ==========================================================
    // Occupancy
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            fill <= 2'h0;
        end else begin
            fill <= 2'(fill + {1'b0, push} - {1'b0, pop});
        end
    end

    // ==========================================================
    // Storage; slot0 is always the head
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            slot0 <= '0;
            slot1 <= '0;
        end else if (pop) begin
            if (fill == 2'h2) begin
                slot0 <= slot1;
            end else begin
                slot0 <= in_data;
            end
            if (push) begin
                slot1 <= in_data;
            end
        end else if (push) begin
            if (fill == 2'h0) begin
                slot0 <= in_data;
            end else begin
                slot1 <= in_data;
            end
        end
    end

endmodule : pair_buffer

`default_nettype wire

//--- idct8x8.sv
// Purpose: Pipelined 8x8 two-dimensional inverse cosine transform core.
// Assumes: start, coef_in and out_ready are synchronous to mclk.
// Notes:   Column pass, eight 32-word transpose RAMs, row pass, saturation.
`default_nettype none

module idct8x8 #(
    parameter int PIX_W_P = idct_pkg::PIX_W,
    parameter bit SIGNED_OUT = 1'b1
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic start,
    input wire logic [idct_pkg::COEF_W-1:0] coef_in,
    input wire logic out_ready,
    output logic [PIX_W_P-1:0] pixel_out,
    output logic pixel_valid,
    output logic ready,
    output logic in_hold
);
    import idct_pkg::*;

    // ==========================================================
    // Derived widths
    localparam int ROW_W = PIX_W_P + 3;
    localparam int ROW_SHIFT = MID_FRAC + TAB_FRAC + OUT_SCALE_LOG - (PIX_W_P - PIX_W);
    localparam int COL_SHIFT = TAB_FRAC - MID_FRAC;
    localparam logic signed [ROW_W-1:0] SAT_HI = ROW_W'((1 <<< (PIX_W_P - 1)) - 1);
    localparam logic signed [ROW_W-1:0] SAT_LO = ROW_W'(-(1 <<< (PIX_W_P - 1)));

    // ==========================================================
    // Declarations
    seq_state_t state;
    logic [7:0] tick;
    logic [7:0] age;
    logic [7:0] ct;
    logic [7:0] rt;
    logic core_en;
    logic sample;
    logic col_go;
    logic row_go;

    logic signed [COEF_W-1:0] coef_mem [0:127];
    logic [8*COEF_W-1:0] col_x;
    logic signed [MID_W-1:0] col_y;
    logic colw_v;
    logic [2:0] colw_bank;
    logic [4:0] colw_addr;

    logic [4:0] row_addr;
    logic [8*MID_W-1:0] row_x;
    logic signed [ROW_W-1:0] row_y;
    logic row_v;
    logic row_first;

    logic [PIX_W_P-1:0] next_sat;
    logic [PIX_W_P-1:0] sat_data;
    logic sat_v;
    logic sat_first;

    logic buf_in_ready;
    logic buf_out_valid;
    logic [PIX_W_P:0] buf_out_data;
    logic pop;
    logic [PIX_W_P-1:0] pend;
    logic pend_v;

    // ==========================================================
    // Sequencer unit
    // The sequencer, capture and both passes advance only when enabled and the output buffer has room.
    assign core_en = ce & buf_in_ready;
    assign sample = (state != SEQ_IDLE) & ~start;
    assign col_go = sample & (age >= COL_OFS);
    assign row_go = sample & (age >= ROW_OFS);
    assign ct = tick - COL_OFS;
    assign rt = tick - ROW_OFS;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state <= SEQ_IDLE;
        end else if (core_en) begin
            unique case (state)
                SEQ_IDLE: begin
                    if (start) begin
                        state <= SEQ_ARMED;
                    end
                end
                SEQ_ARMED: begin
                    if (!start) begin
                        state <= SEQ_RUN;
                    end
                end
                SEQ_RUN: begin
                    if (start) begin
                        state <= SEQ_ARMED;
                    end
                end
                default: begin
                    state <= SEQ_IDLE;
                end
            endcase
        end
    end

    // Tick indexes the stream; age saturates and gates the later passes
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            tick <= 8'h00;
            age <= 8'h00;
        end else if (core_en) begin
            if (start) begin
                tick <= 8'h00;
                age <= 8'h00;
            end else if (sample) begin
                tick <= tick + 8'h01;
                if (age != 8'hFF) begin
                    age <= age + 8'h01;
                end
            end
        end
    end

    // ==========================================================
    // Input capture, two block pages
    always_ff @(posedge mclk) begin
        if (core_en && sample) begin
            coef_mem[{tick[6], tick[5:0]}] <= $signed(coef_in);
        end
    end

    // ==========================================================
    // Transpose RAMs and column operand fetch
    for (genvar b = 0; b < 8; b++) begin : g_bank
        logic signed [MID_W-1:0] col_ram [0:31];

        always_ff @(posedge mclk) begin
            if (core_en && colw_v && colw_bank == 3'(b)) begin
                col_ram[colw_addr] <= col_y;
            end
        end

        assign row_x[b*MID_W +: MID_W] = col_ram[row_addr];
        assign col_x[b*COEF_W +: COEF_W] = coef_mem[{ct[6], 3'(b), ct[5:3]}];
    end

    // ==========================================================
    // Column stage: column ct[5:3], output row ct[2:0]
    point8_stage #(
        .IN_W(COEF_W),
        .OUT_W(MID_W),
        .SHIFT(COL_SHIFT)
    ) column_stage (
        .mclk(mclk),
        .rstn(rstn),
        .en(core_en),
        .x_flat(col_x),
        .sel(ct[2:0]),
        .y(col_y)
    );

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            colw_v <= 1'b0;
            colw_bank <= 3'h0;
            colw_addr <= 5'h00;
        end else if (core_en) begin
            colw_v <= col_go;
            colw_bank <= ct[5:3];
            colw_addr <= {ct[7:6], ct[2:0]};
        end
    end

    // ==========================================================
    // Row stage: row rt[5:3], output column rt[2:0]
    assign row_addr = {rt[7:6], rt[5:3]};

    point8_stage #(
        .IN_W(MID_W),
        .OUT_W(ROW_W),
        .SHIFT(ROW_SHIFT)
    ) row_stage (
        .mclk(mclk),
        .rstn(rstn),
        .en(core_en),
        .x_flat(row_x),
        .sel(rt[2:0]),
        .y(row_y)
    );

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            row_v <= 1'b0;
            row_first <= 1'b0;
        end else if (core_en) begin
            row_v <= row_go;
            row_first <= row_go & (rt[5:0] == 6'h00);
        end
    end

    // ==========================================================
    // Saturation and optional offset
    always_comb begin
        if (row_y > SAT_HI) begin
            next_sat = SAT_HI[PIX_W_P-1:0];
        end else if (row_y < SAT_LO) begin
            next_sat = SAT_LO[PIX_W_P-1:0];
        end else begin
            next_sat = row_y[PIX_W_P-1:0];
        end
        if (!SIGNED_OUT) begin
            next_sat[PIX_W_P-1] = ~next_sat[PIX_W_P-1];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sat_v <= 1'b0;
            sat_first <= 1'b0;
            sat_data <= '0;
        end else if (core_en) begin
            sat_v <= row_v;
            sat_first <= row_first;
            sat_data <= next_sat;
        end
    end

    // ==========================================================
    // Output buffer; a full buffer stalls the core
    pair_buffer #(
        .W(PIX_W_P + 1)
    ) out_buffer (
        .mclk(mclk),
        .rstn(rstn),
        .en(ce),
        .in_valid(sat_v),
        .in_ready(buf_in_ready),
        .in_data({sat_first, sat_data}),
        .out_valid(buf_out_valid),
        .out_ready(out_ready),
        .out_data(buf_out_data)
    );

    assign pop = buf_out_valid & out_ready;

    // ==========================================================
    // Output registers: ready one clock ahead of each block's first result
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ready <= 1'b0;
        end else if (ce) begin
            ready <= pop & buf_out_data[PIX_W_P];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pend <= '0;
            pend_v <= 1'b0;
        end else if (ce) begin
            pend <= buf_out_data[PIX_W_P-1:0];
            pend_v <= pop;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pixel_out <= '0;
            pixel_valid <= 1'b0;
        end else if (ce) begin
            pixel_out <= pend;
            pixel_valid <= pend_v;
        end
    end

    // Back-pressure flag; shows one clock after the buffer fills
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            in_hold <= 1'b0;
        end else if (ce) begin
            in_hold <= ~buf_in_ready;
        end
    end

endmodule : idct8x8

`default_nettype wire

//--- idct_checker.sv
// Purpose: Port-level timing checks of the 8x8 inverse transform core.
// Assumes: ce and out_ready stay high for the latency checks to apply.
// Notes:   Bound to every instance of the core at the foot of this file.
`default_nettype none

module idct_checker #(
    parameter int PIX_W_P = 8
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic start,
    input wire logic [idct_pkg::COEF_W-1:0] coef_in,
    input wire logic out_ready,
    input wire logic [PIX_W_P-1:0] pixel_out,
    input wire logic pixel_valid,
    input wire logic ready,
    input wire logic in_hold
);
    timeunit 1ns;
    timeprecision 1ps;
    import idct_pkg::*;
    logic run;
    logic [11:0] cnt;

    // ==========================================================
    // Cycles since the last start cycle of an unstalled run
    always_ff @(posedge mclk) begin
        if (!rstn || !ce || !out_ready || in_hold) begin
            run <= 1'b0;
        end else if (start) begin
            run <= 1'b1;
        end
    end
    always_ff @(posedge mclk) begin
        if (start) begin
            cnt <= 12'h000;
        end else if (cnt != 12'hFFF) begin
            cnt <= cnt + 12'h001;
        end
    end

    // ==========================================================
    // Assertions
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence s_ready_go;
        run && ready && ce;
    endsequence
    sequence s_first_pix;
        !ready && pixel_valid;
    endsequence

    a_ready_latency: assert property (run && cnt == 12'd181 |-> ready)
        else $error("ready missing at start plus 182");
    a_ready_early: assert property (run && cnt < 12'd181 |-> !ready)
        else $error("ready before block computed");
    a_ready_period: assert property (
        run && cnt > 12'd181 |-> ready == (cnt[5:0] == 6'd53))
        else $error("ready not every 64 cycles");
    a_stream_valid: assert property (run && cnt >= 12'd182 |-> pixel_valid)
        else $error("gap in result stream");
    a_first_word: assert property (s_ready_go |=> s_first_pix)
        else $error("first result not after ready");
    a_ce_freeze: assert property (!ce |=> $stable(pixel_out) && $stable(ready)
        && $stable(pixel_valid) && $stable(in_hold))
        else $error("outputs moved with ce low");
    a_reset_clears: assert property (disable iff (1'b0)
        !rstn |=> !ready && !pixel_valid && !in_hold)
        else $error("outputs active after reset");
    a_hold_release: assert property ((out_ready && ce)[*3] |-> !in_hold)
        else $error("hold kept while receiver ready");
endmodule : idct_checker

bind idct8x8 idct_checker #(.PIX_W_P(PIX_W_P)) idct_checker_inst (
    .mclk(mclk), .rstn(rstn), .ce(ce), .start(start), .coef_in(coef_in),
    .out_ready(out_ready), .pixel_out(pixel_out), .pixel_valid(pixel_valid),
    .ready(ready), .in_hold(in_hold));

`default_nettype wire

//--- frame_buffers.sv
// Purpose: Model of the input and output frame buffers around the core.
// Assumes: Inputs from the bench change at the falling edge.
// Notes:   Word pointer advances only on edges where the core took a word.
`default_nettype none

module frame_buffers (
    input wire logic mclk,
    input wire logic go,
    input wire logic slow,
    input wire logic rnd,
    input wire logic ce,
    input wire logic in_hold,
    input wire logic signed [idct_pkg::COEF_W-1:0] blk_mem [0:255],
    output logic start,
    output logic [idct_pkg::COEF_W-1:0] coef_in,
    output logic out_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    import idct_pkg::*;
    logic [7:0] ptr = 8'h00;
    logic took = 1'b0;

    // An enabled edge without start; in_hold after it tells whether the core took the word
    always @(posedge mclk) begin
        took <= ce && !start;
    end
    always @(negedge mclk) begin
        start <= go;
        out_ready <= !slow || rnd;
        if (go) begin
            ptr <= 8'h00;
        end else if (took && !in_hold) begin
            // A word offered while the core was frozen is offered again
            ptr <= ptr + 8'h01;
        end
    end
    assign coef_in = blk_mem[ptr];
endmodule : frame_buffers

`default_nettype wire

//--- tb_idct8x8.sv
// Purpose: Self-checking bench of the 8x8 inverse transform core.
// Assumes: Expected results from a real-valued separable reference.
// Notes:   Second core is 12-bit unsigned and sees the same stimulus.
`default_nettype none

module tb_idct8x8;
    timeunit 1ns;
    timeprecision 1ps;
    import idct_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic go = 1'b0;
    logic slow = 1'b0;
    logic rnd = 1'b0;
    logic start;
    logic out_ready;
    logic [COEF_W-1:0] coef_in;
    logic [7:0] pixel_out;
    logic [11:0] pixel_wide;
    logic pixel_valid;
    logic ready;
    logic in_hold;
    logic signed [COEF_W-1:0] blk_mem [0:255];
    real exp_q[$];
    real e;
    int err_count = 0;
    int checks_done = 0;

    always #2 mclk = ~mclk;

    idct8x8 idct8x8_inst (.mclk(mclk), .rstn(rstn), .ce(ce), .start(start),
        .coef_in(coef_in), .out_ready(out_ready), .pixel_out(pixel_out),
        .pixel_valid(pixel_valid), .ready(ready), .in_hold(in_hold));
    idct8x8 #(.PIX_W_P(12), .SIGNED_OUT(1'b0)) idct8x8_wide_inst (.mclk(mclk),
        .rstn(rstn), .ce(ce), .start(start), .coef_in(coef_in), .out_ready(out_ready),
        .pixel_out(pixel_wide), .pixel_valid(), .ready(), .in_hold());
    frame_buffers frame_buffers_inst (.mclk(mclk), .go(go), .slow(slow), .rnd(rnd),
        .ce(ce), .in_hold(in_hold), .blk_mem(blk_mem), .start(start),
        .coef_in(coef_in), .out_ready(out_ready));

    // ==========================================================
    // Reference and comparison
    function automatic real cw(input int m, input int k);
        return 0.5 * $cos((2 * m + 1) * k * 3.14159265358979 / 16.0);
    endfunction : cw

    function automatic int scaled(input real v, input real k);
        real x;
        x = v * k;
        if (x > 128.0 * k - 1.0) x = 128.0 * k - 1.0;
        if (x < -128.0 * k) x = -128.0 * k;
        return int'(x);
    endfunction : scaled

    task automatic chk(input logic [15:0] seen, input int expv, input int tol);
        int s;
        s = int'($signed(seen));
        checks_done++;
        if ($isunknown(seen) || s - expv > tol || expv - s > tol) begin
            err_count++;
            $display("[ERR] %0t result %0d expected %0d", $time, s, expv);
        end
    endtask : chk

    always @(posedge mclk) begin
        if (rstn && ce && pixel_valid === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            chk({{8{pixel_out[7]}}, pixel_out}, scaled(e, 1.0), 1);
            chk({4'h0, pixel_wide}, scaled(e, 16.0) + 2048, 16);
        end
        // Each ready falls on a block boundary of the expected stream
        if (rstn && ce && ready === 1'b1) begin
            chk(16'(exp_q.size() % 64), 0, 0);
        end
    end

    // ==========================================================
    // Stimulus
    task automatic reset_dut();
        @(negedge mclk);
        rstn <= 1'b0;
        exp_q.delete();
        repeat (12) @(negedge mclk);
        rstn <= 1'b1;
    endtask : reset_dut

    task automatic load(input int kind);
        real s;
        for (int i = 0; i < 256; i++) begin
            blk_mem[i] = (kind == 0) ? 12'h000 : 12'($urandom_range(4095));
            if (kind == 2 && i >= 64 && i < 192) begin
                blk_mem[i] = (i < 128) ? 12'h7FF : 12'h800;
            end
        end
        for (int p = 0; p < 192; p++) begin
            s = 0.0;
            for (int k = 0; k < 64; k++) begin
                s += blk_mem[p / 64 * 64 + k] * cw(p % 64 / 8, k / 8) * cw(p % 8, k % 8);
            end
            exp_q.push_back(s / 128.0);
        end
    endtask : load

    task automatic run_case(input int kind, input bit rce, input bit rslow);
        int n = 0;
        reset_dut();
        load(kind);
        slow <= rslow;
        @(negedge mclk) go <= 1'b1;
        @(negedge mclk) go <= 1'b0;
        while (exp_q.size() > 0 && n < 6000) begin
            @(negedge mclk);
            ce <= !rce || ($urandom_range(3) != 0);
            rnd <= ($urandom_range(3) == 0);
            n++;
        end
        ce <= 1'b1;
        if (exp_q.size() > 0) begin
            err_count++;
            $display("[ERR] %0t results missing", $time);
        end
    endtask : run_case

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    initial begin
        #80000;
        err_count++;
        $display("[ERR] %0t watchdog expired", $time);
        wrap_up();
    end

    initial begin
        void'($urandom(32'h46EF));
        run_case(2, 1'b0, 1'b0);
        run_case(1, 1'b1, 1'b0);
        run_case(1, 1'b1, 1'b1);
        wrap_up();
    end
endmodule : tb_idct8x8

`default_nettype wire
